// ---- logic/scc_synth_ctrl.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Receive or transmit command starts VCO calibration
// - Calibration lasts 142 us
// - Completion visible in status register 0x339
// - Default settle delay is 56 us
// - Receive entry uses 92 kHz loop bandwidth
// - Transmit bandwidth chosen from data rate
// - Eight selectable loop bandwidth configurations
// - Optional Gaussian filter on transmit bits
// - Table kept until sleep, then cleared
// - Custom enable bit selects programmed settle delay
// - Separate receive and transmit settle registers
// - Custom delay 2 to 512 us, 2 us steps
// - Calibrated band and amplitude read back
module scc_synth_ctrl #(
  parameter int unsigned CAL_CYC    = scc_pkg::CAL_CYC,
  parameter int unsigned SETTLE_CYC = scc_pkg::SETTLE_CYC,
  parameter int unsigned STEP_CYC   = scc_pkg::STEP_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        enter_receive_cmd,
  input  wire logic        enter_transmit_cmd,
  input  wire logic        apply_config_cmd,
  input  wire logic        sleep_cmd,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [10:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  input  wire logic [11:0] data_rate,
  input  wire logic [7:0]  vco_band_meas,
  input  wire logic [7:0]  vco_ampl_meas,
  input  wire logic        tx_bit,
  input  wire logic        tx_bit_stb,
  output logic      [2:0]  tx_shape_q,
  output logic      [2:0]  bw_sel_q,
  output logic      [7:0]  vco_band_drv_q,
  output logic      [7:0]  vco_ampl_drv_q,
  output logic             cal_active,
  output logic             synth_settled,
  output logic             receive_state,
  output logic             transmit_state
);
  localparam int unsigned CW = scc_pkg::CNT_W;

  scc_pkg::scc_state_t state_q;
  scc_pkg::scc_state_t state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] settle_len;
  logic [CW-1:0] age_q;
  logic [7:0]    cfg7_q;
  logic [7:0]    cfg9_q;
  logic [7:0]    opt_q;
  logic [7:0]    rx_settle_q;
  logic [7:0]    tx_settle_q;
  logic [7:0]    cal_ctrl_q;
  logic [7:0]    band_ovr_q;
  logic [7:0]    ampl_ovr_q;
  logic [7:0]    ovr_en_q;
  logic [7:0]    cal_opt_q;
  logic [7:0]    band_res_q;
  logic [7:0]    ampl_res_q;
  logic [7:0]    reg_rdata_q;
  logic          lut_hit_q;
  logic          cal_done_q;
  logic          opt_bw_q;
  logic          dir_tx_q;
  logic          go;
  logic          bypass;
  logic          custom;
  logic          lut_range;
  logic [7:0]    lut_rdata;
  logic          lut_loaded;
  logic [7:0]    settle_reg;
  logic [2:0]    tx_bw;
  logic [2:0]    bit_hist_q;

  assign go        = enter_receive_cmd | enter_transmit_cmd;
  assign bypass    = ovr_en_q == scc_pkg::OVR_EN_BYPASS &&
                     cal_opt_q == scc_pkg::CAL_OPT_BYPASS &&
                     cal_ctrl_q[scc_pkg::SYNTH_CAL_BIT];
  assign custom    = opt_q[scc_pkg::CUST_SETTLE_BIT];
  assign lut_range = mem_addr >= scc_pkg::LUT_FIRST_ADR &&
                     mem_addr <= scc_pkg::LUT_LAST_ADR;

  // Custom delay is (value + 1) steps, so 0 gives 2 us and 255 gives 512 us
  assign settle_reg = (go ? enter_transmit_cmd : dir_tx_q) ? tx_settle_q : rx_settle_q;
  assign settle_len = custom ?
                      CW'((32'(settle_reg) + 32'd1) * STEP_CYC) :
                      CW'(SETTLE_CYC);

  scc_lut_ram #(
    .DEPTH (scc_pkg::LUT_DEPTH),
    .AW    (4)
  ) u_lut (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (sleep_cmd),
    .we       (mem_wr && lut_range),
    .addr     (4'(mem_addr - scc_pkg::LUT_FIRST_ADR)),
    .wdata    (mem_wdata),
    .rdata_q  (lut_rdata),
    .loaded_q (lut_loaded)
  );

  // Sequencer: a command restarts calibration from any state, or settling when bypassed; sleep in the same cycle wins
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      scc_pkg::SCC_IDLE:   state_d = scc_pkg::SCC_IDLE;
      scc_pkg::SCC_CAL:    if (cnt_q == CW'(1)) state_d = scc_pkg::SCC_SETTLE;
      scc_pkg::SCC_SETTLE: if (cnt_q == CW'(1)) state_d = scc_pkg::SCC_READY;
      scc_pkg::SCC_READY:  state_d = scc_pkg::SCC_READY;
    endcase
    if (go) begin
      state_d = bypass ? scc_pkg::SCC_SETTLE : scc_pkg::SCC_CAL;
    end
    if (sleep_cmd) begin
      state_d = scc_pkg::SCC_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= scc_pkg::SCC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_tx_q <= 1'b0;
    end else if (go) begin
      dir_tx_q <= enter_transmit_cmd;
    end
  end

  // Cycle counter for calibration and settling
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (state_d != state_q || go) begin
      if (state_d == scc_pkg::SCC_CAL) begin
        cnt_q <= CW'(CAL_CYC);
      end else if (state_d == scc_pkg::SCC_SETTLE) begin
        cnt_q <= settle_len;
      end else begin
        cnt_q <= '0;
      end
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  // Done flag; a bypassed command cutting calibration short leaves it alone
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_done_q <= 1'b0;
    end else if (go && !bypass) begin
      cal_done_q <= 1'b0;
    end else if (state_q == scc_pkg::SCC_CAL && state_d == scc_pkg::SCC_SETTLE && !go) begin
      cal_done_q <= 1'b1;
    end
  end

  // Results latch at the end of calibration; drive outputs take overrides when bypassed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      band_res_q <= scc_pkg::REG_RST;
      ampl_res_q <= scc_pkg::REG_RST;
    end else if (state_q == scc_pkg::SCC_CAL && state_d == scc_pkg::SCC_SETTLE && !go) begin
      band_res_q <= vco_band_meas;
      ampl_res_q <= vco_ampl_meas;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_band_drv_q <= 8'h00;
      vco_ampl_drv_q <= 8'h00;
    end else if (go && bypass) begin
      vco_band_drv_q <= band_ovr_q;
      vco_ampl_drv_q <= ampl_ovr_q;
    end else if (state_q == scc_pkg::SCC_CAL && state_d == scc_pkg::SCC_SETTLE) begin
      vco_band_drv_q <= vco_band_meas;
      vco_ampl_drv_q <= vco_ampl_meas;
    end
  end

  // Loop bandwidth pick for transmit from data rate in 100 bps units
  always_comb begin
    if (opt_bw_q && lut_loaded) tx_bw = scc_pkg::BW_TX_LUT;
    else if (data_rate <= scc_pkg::RATE_T1) tx_bw = scc_pkg::BW_TX_130;
    else if (data_rate <= scc_pkg::RATE_T2) tx_bw = scc_pkg::BW_TX_174A;
    else if (data_rate <= scc_pkg::RATE_T3) tx_bw = scc_pkg::BW_TX_174B;
    else if (data_rate <= scc_pkg::RATE_T4) tx_bw = scc_pkg::BW_TX_226;
    else if (data_rate <= scc_pkg::RATE_T5) tx_bw = scc_pkg::BW_TX_305;
    else tx_bw = scc_pkg::BW_TX_382;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bw_sel_q <= scc_pkg::BW_RX_92;
    end else if (go) begin
      bw_sel_q <= enter_transmit_cmd ? tx_bw : scc_pkg::BW_RX_92;
    end
  end

  // Optimized transmit bandwidth takes effect on the configure command
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_bw_q <= 1'b0;
    end else if (apply_config_cmd) begin
      opt_bw_q <= cfg7_q[scc_pkg::OPT_BW_LSB +: 2] == scc_pkg::OPT_BW_CODE;
    end
  end

  // Transmit shaping: 1-2-1 kernel when enabled, raw level otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_hist_q <= 3'h0;
    end else if (tx_bit_stb) begin
      bit_hist_q <= {bit_hist_q[1:0], tx_bit};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shape_q <= 3'h0;
    end else if (cfg9_q[scc_pkg::GAUSS_BIT]) begin
      tx_shape_q <= 3'(bit_hist_q[2]) + {1'b0, bit_hist_q[1], 1'b0} +
                    3'(bit_hist_q[0]);
    end else begin
      tx_shape_q <= {bit_hist_q[1], 2'b00};
    end
  end

  // Register writes; read-only locations ignore writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg7_q      <= scc_pkg::REG_RST;
      cfg9_q      <= scc_pkg::REG_RST;
      opt_q       <= scc_pkg::REG_RST;
      rx_settle_q <= scc_pkg::REG_RST;
      tx_settle_q <= scc_pkg::REG_RST;
      cal_ctrl_q  <= scc_pkg::REG_RST;
      band_ovr_q  <= scc_pkg::REG_RST;
      ampl_ovr_q  <= scc_pkg::REG_RST;
      ovr_en_q    <= scc_pkg::REG_RST;
      cal_opt_q   <= scc_pkg::REG_RST;
    end else if (mem_wr) begin
      unique case (mem_addr)
        scc_pkg::RADIO_CFG7_ADR: cfg7_q      <= mem_wdata;
        scc_pkg::RADIO_CFG9_ADR: cfg9_q      <= mem_wdata;
        scc_pkg::OPT_ADR:        opt_q       <= mem_wdata;
        scc_pkg::RX_SETTLE_ADR:  rx_settle_q <= mem_wdata;
        scc_pkg::TX_SETTLE_ADR:  tx_settle_q <= mem_wdata;
        scc_pkg::CAL_CTRL_ADR:   cal_ctrl_q  <= mem_wdata;
        scc_pkg::BAND_OVR_ADR:   band_ovr_q  <= mem_wdata;
        scc_pkg::AMPL_OVR_ADR:   ampl_ovr_q  <= mem_wdata;
        scc_pkg::OVR_EN_ADR:     ovr_en_q    <= mem_wdata;
        scc_pkg::CAL_OPT_ADR:    cal_opt_q   <= mem_wdata;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      lut_hit_q   <= 1'b0;
    end else if (mem_rd) begin
      lut_hit_q <= lut_range;
      unique case (mem_addr)
        scc_pkg::RADIO_CFG7_ADR: reg_rdata_q <= cfg7_q;
        scc_pkg::RADIO_CFG9_ADR: reg_rdata_q <= cfg9_q;
        scc_pkg::OPT_ADR:        reg_rdata_q <= opt_q;
        scc_pkg::RX_SETTLE_ADR:  reg_rdata_q <= rx_settle_q;
        scc_pkg::TX_SETTLE_ADR:  reg_rdata_q <= tx_settle_q;
        scc_pkg::CAL_CTRL_ADR:   reg_rdata_q <= cal_ctrl_q;
        scc_pkg::CAL_PROG_ADR:   reg_rdata_q <= {4'h0, lut_loaded,
                                                 state_q == scc_pkg::SCC_READY,
                                                 state_q == scc_pkg::SCC_CAL,
                                                 cal_done_q};
        scc_pkg::BAND_OVR_ADR:   reg_rdata_q <= band_ovr_q;
        scc_pkg::AMPL_OVR_ADR:   reg_rdata_q <= ampl_ovr_q;
        scc_pkg::OVR_EN_ADR:     reg_rdata_q <= ovr_en_q;
        scc_pkg::CAL_OPT_ADR:    reg_rdata_q <= cal_opt_q;
        scc_pkg::BAND_RES_ADR:   reg_rdata_q <= band_res_q;
        scc_pkg::AMPL_RES_ADR:   reg_rdata_q <= ampl_res_q;
        default:                 reg_rdata_q <= 8'h00;
      endcase
    end
  end

  assign mem_rdata      = lut_hit_q ? lut_rdata : reg_rdata_q;
  assign cal_active     = state_q == scc_pkg::SCC_CAL;
  assign synth_settled  = state_q == scc_pkg::SCC_READY;
  assign receive_state  = state_q != scc_pkg::SCC_IDLE && !dir_tx_q;
  assign transmit_state = state_q != scc_pkg::SCC_IDLE && dir_tx_q;

  // Cycles spent in the present state, for checking only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_q <= '0;
    end else if (state_d != state_q || go) begin
      age_q <= CW'(1);
    end else if (age_q != '1) begin
      age_q <= age_q + CW'(1);
    end
  end

  cmd_starts_cal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && !bypass && !sleep_cmd |=> state_q == scc_pkg::SCC_CAL && !cal_done_q)
    else $error("Command did not start calibration");

  cal_length_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == scc_pkg::SCC_CAL && state_d == scc_pkg::SCC_SETTLE && !go
    |-> age_q == CW'(CAL_CYC))
    else $error("Calibration length wrong");

  status_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == scc_pkg::SCC_CAL && state_d == scc_pkg::SCC_SETTLE && !go |=> cal_done_q)
    else $error("Done flag missing after calibration");

  default_settle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == scc_pkg::SCC_SETTLE && state_d == scc_pkg::SCC_READY && !custom
    |-> age_q == CW'(SETTLE_CYC))
    else $error("Default settle length wrong");

  custom_settle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == scc_pkg::SCC_SETTLE && state_d == scc_pkg::SCC_READY && custom
    |-> 32'(age_q) == (32'(settle_reg) + 32'd1) * STEP_CYC)
    else $error("Custom settle length wrong");

  rx_bw_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    enter_receive_cmd && !enter_transmit_cmd |=> bw_sel_q == scc_pkg::BW_RX_92)
    else $error("Receive bandwidth wrong");

  tx_bw_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    enter_transmit_cmd && !opt_bw_q && data_rate > scc_pkg::RATE_T5
    |=> bw_sel_q == scc_pkg::BW_TX_382)
    else $error("Transmit bandwidth wrong");

  gauss_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfg9_q[scc_pkg::GAUSS_BIT] && !tx_bit_stb && !$changed(cfg9_q)
    |=> tx_shape_q == {$past(bit_hist_q[1]), 2'b00})
    else $error("Unshaped level wrong");

  result_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == scc_pkg::SCC_CAL && state_d == scc_pkg::SCC_SETTLE && !go
    |=> band_res_q == $past(vco_band_meas) && ampl_res_q == $past(vco_ampl_meas))
    else $error("Calibration result not stored");

  lut_sleep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sleep_cmd |=> !lut_loaded && state_q == scc_pkg::SCC_IDLE)
    else $error("Table kept across sleep");
endmodule : scc_synth_ctrl

// ---- logic/scc_pkg.sv ----
package scc_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned CAL_US        = 142;
  localparam int unsigned SETTLE_US     = 56;
  localparam int unsigned STEP_US       = 2;
  localparam int unsigned CAL_CYC       = CAL_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYC    = SETTLE_US * CLK_MHZ;
  localparam int unsigned STEP_CYC      = STEP_US * CLK_MHZ;
  localparam int unsigned CNT_W         = 17;

  localparam logic [10:0] RADIO_CFG7_ADR  = 11'h113;
  localparam logic [10:0] RADIO_CFG9_ADR  = 11'h115;
  localparam logic [10:0] OPT_ADR         = 11'h11a;
  localparam logic [10:0] RX_SETTLE_ADR   = 11'h13e;
  localparam logic [10:0] TX_SETTLE_ADR   = 11'h13f;
  localparam logic [10:0] CAL_CTRL_ADR    = 11'h338;
  localparam logic [10:0] CAL_PROG_ADR    = 11'h339;
  localparam logic [10:0] BAND_OVR_ADR    = 11'h3cb;
  localparam logic [10:0] AMPL_OVR_ADR    = 11'h3cc;
  localparam logic [10:0] OVR_EN_ADR      = 11'h3cd;
  localparam logic [10:0] CAL_OPT_ADR     = 11'h3d0;
  localparam logic [10:0] BAND_RES_ADR    = 11'h3da;
  localparam logic [10:0] AMPL_RES_ADR    = 11'h3db;
  localparam logic [10:0] LUT_FIRST_ADR   = 11'h010;
  localparam logic [10:0] LUT_LAST_ADR    = 11'h018;
  localparam int unsigned LUT_DEPTH       = 9;

  localparam logic [7:0] REG_RST         = 8'h00;
  localparam int unsigned OPT_BW_LSB      = 4;
  localparam logic [1:0] OPT_BW_CODE     = 2'h2;
  localparam int unsigned GAUSS_BIT       = 7;
  localparam int unsigned CUST_SETTLE_BIT = 3;
  localparam int unsigned SYNTH_CAL_BIT   = 0;
  localparam logic [7:0] OVR_EN_BYPASS   = 8'h03;
  localparam logic [7:0] CAL_OPT_BYPASS  = 8'h0f;
  localparam int unsigned ST_DONE_BIT     = 0;
  localparam int unsigned ST_PEND_BIT     = 1;
  localparam int unsigned ST_SETTLED_BIT  = 2;
  localparam int unsigned ST_LUT_BIT      = 3;

  localparam logic [11:0] RATE_T1 = 12'h1ef;
  localparam logic [11:0] RATE_T2 = 12'h3df;
  localparam logic [11:0] RATE_T3 = 12'h50f;
  localparam logic [11:0] RATE_T4 = 12'h6ff;
  localparam logic [11:0] RATE_T5 = 12'h95f;

  localparam logic [2:0] BW_RX_92   = 3'h0;
  localparam logic [2:0] BW_TX_130  = 3'h1;
  localparam logic [2:0] BW_TX_174A = 3'h2;
  localparam logic [2:0] BW_TX_174B = 3'h3;
  localparam logic [2:0] BW_TX_226  = 3'h4;
  localparam logic [2:0] BW_TX_305  = 3'h5;
  localparam logic [2:0] BW_TX_382  = 3'h6;
  localparam logic [2:0] BW_TX_LUT  = 3'h7;

  typedef enum logic [1:0] {
    SCC_IDLE   = 2'b00,
    SCC_CAL    = 2'b01,
    SCC_SETTLE = 2'b10,
    SCC_READY  = 2'b11
  } scc_state_t;
endpackage : scc_pkg

// ---- logic/scc_lut_ram.sv ----
`timescale 1ns/1ns
module scc_lut_ram #(
  parameter int unsigned DEPTH = 9,
  parameter int unsigned AW    = 4
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          clear,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_q,
  output logic               loaded_q
);
  logic [7:0] mem_q [DEPTH];

  // Contents drop on clear, as when power to the table goes away
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= 8'h00;
    end else if (clear) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= 8'h00;
    end else if (we && addr < AW'(DEPTH)) begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= (addr < AW'(DEPTH)) ? mem_q[addr] : 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_q <= 1'b0;
    end else if (clear) begin
      loaded_q <= 1'b0;
    end else if (we && addr == AW'(DEPTH - 1)) begin
      loaded_q <= 1'b1;
    end
  end
endmodule : scc_lut_ram

// ---- sim/scc_host_model.sv ----
`timescale 1ns/1ns
module scc_host_model (
  input  wire logic        core_clk,
  output logic             enter_receive_cmd,
  output logic             enter_transmit_cmd,
  output logic             apply_config_cmd,
  output logic             sleep_cmd,
  output logic             mem_wr,
  output logic             mem_rd,
  output logic      [10:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata
);
  localparam logic [7:0] LUT_50K [9] = '{8'h10, 8'h10, 8'h0f, 8'h0f, 8'h1f, 8'h0f, 8'h1f,
                                         8'h33, 8'h22};
  logic [7:0] band_store;
  logic [7:0] ampl_store;
  logic [7:0] q;

  initial begin
    {enter_receive_cmd, enter_transmit_cmd, apply_config_cmd, sleep_cmd} = 4'h0;
    {mem_wr, mem_rd} = 2'h0;
    mem_addr  = 11'h000;
    mem_wdata = 8'h00;
  end

  // One memory access; strobes drop, address and data lines show the inverse of their last value
  task automatic access(input logic w, input logic [10:0] a, input logic [7:0] d,
                        output logic [7:0] rq);
    @(posedge core_clk);
    #1;
    mem_wr    = w;
    mem_rd    = ~w;
    mem_addr  = a;
    mem_wdata = d;
    @(posedge core_clk);
    #1;
    rq        = mem_rdata;
    mem_wr    = 1'b0;
    mem_rd    = 1'b0;
    mem_addr  = ~a;
    mem_wdata = ~d;
  endtask : access

  // Order: receive, transmit, apply config, sleep
  task automatic cmd(input logic [3:0] v);
    @(posedge core_clk);
    #1;
    {enter_receive_cmd, enter_transmit_cmd, apply_config_cmd, sleep_cmd} = v;
    @(posedge core_clk);
    #1;
    {enter_receive_cmd, enter_transmit_cmd, apply_config_cmd, sleep_cmd} = 4'h0;
  endtask : cmd

  task automatic setup_bw;
    access(1'b1, scc_pkg::RADIO_CFG7_ADR, 8'h20, q);
    cmd(4'h2);
  endtask : setup_bw

  task automatic load_lut;
    for (int i = 0; i < 9; i++) begin
      access(1'b1, scc_pkg::LUT_FIRST_ADR + 11'(i), LUT_50K[i], q);
    end
  endtask : load_lut

  task automatic store_cal;
    access(1'b0, scc_pkg::BAND_RES_ADR, 8'h00, band_store);
    access(1'b0, scc_pkg::AMPL_RES_ADR, 8'h00, ampl_store);
  endtask : store_cal

  task automatic bypass;
    access(1'b1, scc_pkg::OVR_EN_ADR, 8'h03, q);
    access(1'b1, scc_pkg::CAL_OPT_ADR, 8'h0f, q);
    access(1'b1, scc_pkg::BAND_OVR_ADR, band_store, q);
    access(1'b1, scc_pkg::AMPL_OVR_ADR, ampl_store, q);
    access(1'b1, scc_pkg::CAL_CTRL_ADR, 8'h00, q);
    access(1'b1, scc_pkg::CAL_CTRL_ADR, 8'h01, q);
  endtask : bypass
endmodule : scc_host_model

// ---- sim/tb.sv ----
`timescale 1ns/1ns
module tb;
  localparam int unsigned CAL = 20;
  localparam int unsigned SET = 8;
  localparam int unsigned STP = 2;
  localparam logic [11:0] RATES [8] = '{12'h001, 12'h1ef, 12'h1f0, 12'h3e0, 12'h510,
                                        12'h700, 12'h960, 12'hbb8};
  localparam logic [2:0]  BWS   [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        rx_c, tx_c, cfg_c, slp_c, mem_wr, mem_rd, tx_bit, tx_bit_stb;
  logic [10:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, band_meas, ampl_meas, band_drv, ampl_drv, q;
  logic [11:0] data_rate;
  logic [2:0]  tx_shape_q, bw_sel_q;
  logic        cal_active, synth_settled, receive_state, transmit_state;
  int          fail_count = 0;
  int          n_tests = 0;
  int          nc, ns;

  always #5 core_clk = ~core_clk;

  assign ampl_meas = band_meas ^ 8'h66;

  scc_synth_ctrl #(.CAL_CYC(CAL), .SETTLE_CYC(SET), .STEP_CYC(STP)) u_scc_synth_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .enter_receive_cmd(rx_c), .enter_transmit_cmd(tx_c),
    .apply_config_cmd(cfg_c), .sleep_cmd(slp_c), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .data_rate(data_rate),
    .vco_band_meas(band_meas), .vco_ampl_meas(ampl_meas), .tx_bit(tx_bit),
    .tx_bit_stb(tx_bit_stb), .tx_shape_q(tx_shape_q), .bw_sel_q(bw_sel_q),
    .vco_band_drv_q(band_drv), .vco_ampl_drv_q(ampl_drv), .cal_active(cal_active),
    .synth_settled(synth_settled), .receive_state(receive_state),
    .transmit_state(transmit_state));

  scc_host_model u_scc_host_model (
    .core_clk(core_clk), .enter_receive_cmd(rx_c), .enter_transmit_cmd(tx_c),
    .apply_config_cmd(cfg_c), .sleep_cmd(slp_c), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    u_scc_host_model.access(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    u_scc_host_model.access(1'b0, a, 8'h00, q);
    check(16'(q), 16'(e));
  endtask : rd

  // Counts calibration cycles, then cycles until settled
  task automatic measure(input int ec, input int es);
    nc = 0;
    ns = 0;
    while (cal_active === 1'b1 && nc < 1000) begin
      @(posedge core_clk);
      #1;
      nc++;
    end
    while (synth_settled !== 1'b1 && ns < 1000) begin
      @(posedge core_clk);
      #1;
      ns++;
    end
    if (nc >= 1000 || ns >= 1000) begin
      fail_count++;
      report_and_stop();
    end
    check(16'(nc), 16'(ec));
    check(16'(ns), 16'(es));
  endtask : measure

  task automatic shape(input logic [2:0] e);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      #1;
      tx_bit     = (i == 1);
      tx_bit_stb = 1'b1;
      @(posedge core_clk);
      #1;
      tx_bit_stb = 1'b0;
    end
    @(posedge core_clk);
    #1;
    check(16'(tx_shape_q), 16'(e));
  endtask : shape

  initial begin
    {rst_n, tx_bit, tx_bit_stb} = 3'h0;
    data_rate = 12'h000;
    band_meas = 8'h5a;
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    check(16'({cal_active, synth_settled, receive_state, transmit_state, bw_sel_q}), 16'h0);
    rd(scc_pkg::CAL_PROG_ADR, 8'h00);
    wr(scc_pkg::RX_SETTLE_ADR, 8'ha5);
    rd(scc_pkg::RX_SETTLE_ADR, 8'ha5);
    wr(scc_pkg::CAL_PROG_ADR, 8'hff);
    rd(scc_pkg::CAL_PROG_ADR, 8'h00);
    rd(11'h200, 8'h00);
    // Receive entry with default settling
    u_scc_host_model.cmd(4'h8);
    check(16'(bw_sel_q), 16'(scc_pkg::BW_RX_92));
    check(16'(receive_state), 16'h1);
    rd(scc_pkg::CAL_PROG_ADR, 8'h02);
    measure(CAL - 2, SET);
    rd(scc_pkg::CAL_PROG_ADR, 8'h05);
    u_scc_host_model.store_cal();
    check(16'({u_scc_host_model.band_store, u_scc_host_model.ampl_store}), 16'h5a3c);
    // Transmit bandwidth across data rate boundaries
    for (int i = 0; i < 8; i++) begin
      data_rate = RATES[i];
      u_scc_host_model.cmd(4'h4);
      check(16'({transmit_state, bw_sel_q}), 16'({1'b1, BWS[i]}));
    end
    measure(CAL, SET);
    // Custom settling, shortest and longest
    wr(scc_pkg::OPT_ADR, 8'h08);
    wr(scc_pkg::TX_SETTLE_ADR, 8'h00);
    wr(scc_pkg::RX_SETTLE_ADR, 8'hff);
    u_scc_host_model.cmd(4'h4);
    measure(CAL, STP);
    u_scc_host_model.cmd(4'h8);
    check(16'({receive_state, bw_sel_q}), 16'({1'b1, scc_pkg::BW_RX_92}));
    measure(CAL, 256 * STP);
    // Transmit bit shaping on and off
    wr(scc_pkg::RADIO_CFG9_ADR, 8'h80);
    shape(3'h2);
    wr(scc_pkg::RADIO_CFG9_ADR, 8'h00);
    shape(3'h4);
    // Custom table, then loss on sleep
    data_rate = 12'h1f4;
    u_scc_host_model.setup_bw();
    u_scc_host_model.load_lut();
    rd(scc_pkg::LUT_LAST_ADR, 8'h22);
    rd(scc_pkg::CAL_PROG_ADR, 8'h0d);
    u_scc_host_model.cmd(4'h4);
    check(16'(bw_sel_q), 16'(scc_pkg::BW_TX_LUT));
    u_scc_host_model.cmd(4'h1);
    check(16'(transmit_state), 16'h0);
    rd(scc_pkg::LUT_FIRST_ADR, 8'h00);
    u_scc_host_model.cmd(4'h4);
    check(16'(bw_sel_q), 16'(scc_pkg::BW_TX_174A));
    // Calibration bypass with stored values
    band_meas = 8'h77;
    u_scc_host_model.bypass();
    u_scc_host_model.cmd(4'h8);
    measure(0, 256 * STP);
    check(16'({band_drv, ampl_drv}), 16'h5a3c);
    rd(scc_pkg::BAND_RES_ADR, 8'h5a);
    rd(scc_pkg::CAL_PROG_ADR, 8'h04);
    report_and_stop();
  end
endmodule : tb
